// File: inc/vok_pkg.sv
// Shared constants and carriers for the program output stage.
// Assumes one 100 MHz clock; register offsets are byte addresses.
package vok_pkg;
    // Raster defaults (standard definition)
    localparam int H_ACT_DEF = 720;
    localparam int V_ACT_DEF = 486;
    localparam int H_TOT_DEF = 858;
    localparam int V_TOT_DEF = 525;
    localparam int H_W = 12;
    localparam int V_W = 10;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOFS = 8'h04;
    localparam logic [7:0] OFS_VOFS = 8'h08;
    localparam logic [7:0] OFS_MATTE = 8'h0C;
    localparam logic [7:0] OFS_IMG_SIZE = 8'h10;
    localparam logic [7:0] OFS_IMG_DATA = 8'h14;
    localparam logic [7:0] OFS_PATTERN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // Control field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_SYNC_LSB = 3;
    localparam int CTRL_KEY_LSB = 5;
    localparam int CTRL_PREM_BIT = 7;
    localparam int CTRL_AUD_BIT = 8;
    localparam int CTRL_HD_BIT = 9;
    localparam int IMG_H_LSB = 16;

    // Reset values
    localparam logic [9:0] CTRL_RST = 10'h002;
    localparam logic [23:0] MATTE_RST = 24'h10_8080;
    localparam logic [31:0] BLACK_PIX = 32'hFF10_8080;

    typedef enum logic [2:0]
    {
        SRC_DESK = 3'b000,
        SRC_PASS = 3'b001,
        SRC_BLACK = 3'b010,
        SRC_TEST = 3'b011,
        SRC_HOLD = 3'b100
    } vok_src_type;

    typedef enum logic [1:0]
    {
        SYNC_FREE = 2'b00,
        SYNC_REF = 2'b01,
        SYNC_VID = 2'b10
    } vok_sync_type;

    typedef enum logic [1:0]
    {
        KEY_OFF = 2'b00,
        KEY_MATTE = 2'b01,
        KEY_INPUT = 2'b10
    } vok_key_type;

    typedef enum logic [0:0]
    {
        FILL_IDLE = 1'b0,
        FILL_RUN = 1'b1
    } vok_fill_type;

    // Pixel: alpha, luma, blue and red difference
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } vok_pix_type;

    typedef struct packed {
        logic sof;
        logic [23:0] pix;
    } vok_vid_type;

    typedef struct packed {
        logic [H_W-1:0] h;
        logic [V_W-1:0] v;
    } vok_tpos_type;

    typedef struct packed {
        logic vld;
        logic sof;
        logic act;
        logic app;
        vok_src_type src;
        vok_key_type key;
        logic prem;
        vok_pix_type in_pix;
        vok_pix_type desk_pix;
        vok_pix_type app_pix;
    } vok_s1_type;
endpackage

// File: logic/vok_timing.sv
// Raster counter for the program output with optional lock to a frame pulse.
// Assumes ext_sof is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module vok_timing
    import vok_pkg::*;
#(
    parameter int H_TOT = H_TOT_DEF,
    parameter int V_TOT = V_TOT_DEF
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic adv,
    input wire logic lock,
    input wire logic ext_sof,
    input wire logic [H_W-1:0] hofs,
    input wire logic [V_W-1:0] vofs,
    // Position
    output logic [H_W-1:0] h,
    output logic [V_W-1:0] v,
    output logic last
);
    vok_tpos_type st_r;
    vok_tpos_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (lock && ext_sof)
        begin
            // Start offset clocks and lines after the pulse
            if (hofs == '0 || 32'(hofs) >= H_TOT)
                st_nxt.h = '0;
            else
                st_nxt.h = H_W'(H_TOT - 32'(hofs));
            if (vofs == '0 || 32'(vofs) >= V_TOT)
                st_nxt.v = '0;
            else
                st_nxt.v = V_W'(V_TOT - 32'(vofs));
        end
        else if (adv)
        begin
            if (32'(st_r.h) == H_TOT - 1)
            begin
                st_nxt.h = '0;
                st_nxt.v = (32'(st_r.v) == V_TOT - 1) ? '0 : st_r.v + 1'b1;
            end
            else
                st_nxt.h = st_r.h + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign h = st_r.h;
    assign v = st_r.v;
    assign last = (32'(st_r.h) == H_TOT - 1) && (32'(st_r.v) == V_TOT - 1);
endmodule

// File: logic/vok_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may hold ready low for any time.
`timescale 1ns/1ps
module vok_skid
#(
    parameter int W = 25
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic v0;
        logic v1;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } vok_skid_type;

    vok_skid_type st_r;
    vok_skid_type st_nxt;
    logic push;
    logic pop;

    always_comb
    begin
        st_nxt = st_r;
        push = in_valid && !st_r.v1;
        pop = st_r.v0 && out_ready;
        if (!st_r.v0)
        begin
            st_nxt.v0 = push;
            st_nxt.d0 = in_data;
        end
        else if (pop)
        begin
            if (st_r.v1)
            begin
                st_nxt.d0 = st_r.d1;
                st_nxt.v1 = push;
                st_nxt.d1 = in_data;
            end
            else
            begin
                st_nxt.v0 = push;
                st_nxt.d0 = in_data;
            end
        end
        else if (push)
        begin
            st_nxt.v1 = 1'b1;
            st_nxt.d1 = in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Ready comes from a flop so the stall path stays short
    assign in_ready = !st_r.v1;
    assign out_valid = st_r.v0;
    assign out_data = st_r.d0;
endmodule

// File: logic/vok_top.sv
// Program output stage: default source, genlock, offsets, compositor, audio.
// Assumes pixel sources present the pixel at RASTER_X/RASTER_Y.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module vok_top
    import vok_pkg::*;
#(
    parameter int H_ACT = H_ACT_DEF,
    parameter int V_ACT = V_ACT_DEF,
    parameter int H_TOT = H_TOT_DEF,
    parameter int V_TOT = V_TOT_DEF
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Pixel sources
    input wire logic APP_ACTIVE,
    input wire vok_pix_type APP_PIX,
    input wire vok_pix_type IN_PIX,
    input wire vok_pix_type DESK_PIX,
    input wire logic REF_SOF,
    input wire logic IN_SOF,
    output logic [H_W-1:0] RASTER_X,
    output logic [V_W-1:0] RASTER_Y,
    // Program video out
    output logic VID_VALID,
    input wire logic VID_READY,
    output logic VID_SOF,
    output logic [23:0] VID_PIX,
    // Audio
    input wire logic [23:0] FB_AUD,
    input wire logic [23:0] IN_AUD,
    output logic [23:0] AUD_OUT
);
    localparam int FB_DEPTH = H_ACT * V_ACT;
    localparam int FB_AW = $clog2(FB_DEPTH);

    typedef struct packed {
        logic [9:0] ctrl;
        logic [H_W-1:0] hofs;
        logic [V_W-1:0] vofs;
        logic [23:0] matte;
        logic [H_W-1:0] img_w;
        logic [V_W-1:0] img_h;
        logic [H_W-1:0] ld_col;
        logic [V_W-1:0] ld_row;
        vok_sync_type a_sync;
        logic [H_W-1:0] a_hofs;
        logic [V_W-1:0] a_vofs;
        vok_key_type a_key;
        logic a_prem;
        vok_fill_type fill;
        logic [H_W-1:0] fx;
        logic [V_W-1:0] fy;
        logic [31:0] rdata;
        vok_s1_type s1;
        logic [23:0] aud;
    } vok_main_type;

    vok_main_type st_r;
    vok_main_type st_nxt;

    // Image, test pattern or last application frame
    logic [31:0] fstore [FB_DEPTH];
    logic [31:0] mem_q;
    logic mem_we;
    logic [FB_AW-1:0] mem_wa;
    logic [31:0] mem_wd;

    logic [H_W-1:0] t_h;
    logic [V_W-1:0] t_v;
    logic t_last;
    logic adv;
    logic ext_sof;
    logic t_act;
    vok_pix_type pgm;
    vok_pix_type outp;
    vok_vid_type vid_in;
    vok_vid_type vid_out;
    logic [H_W-1:0] dx;
    logic [V_W-1:0] dy;

    function automatic logic [FB_AW-1:0] fb_addr(input logic [H_W-1:0] x,
                                                 input logic [V_W-1:0] y);
        fb_addr = FB_AW'(32'(y) * H_ACT + 32'(x));
    endfunction

    // Divide by 255 with rounding
    function automatic logic [7:0] div255(input logic [15:0] p);
        logic [16:0] q;
        q = 17'(p) + 17'h0080;
        div255 = 8'((q + (q >> 8)) >> 8);
    endfunction

    function automatic logic [7:0] mix(input logic [7:0] f, input logic [7:0] b,
                                       input logic [7:0] a, input logic pm);
        logic [7:0] fw;
        logic [8:0] s;
        fw = pm ? f : div255({8'h00, f} * {8'h00, a});
        s = {1'b0, fw} + {1'b0, div255({8'h00, b} * {8'h00, 8'hFF - a})};
        mix = s[8] ? 8'hFF : s[7:0];
    endfunction

    function automatic vok_pix_type comp(input vok_pix_type f, input vok_pix_type b,
                                         input logic pm);
        comp.a = 8'hFF;
        comp.y = mix(f.y, b.y, f.a, pm);
        comp.cb = mix(f.cb, b.cb, f.a, pm);
        comp.cr = mix(f.cr, b.cr, f.a, pm);
    endfunction

    // Eight vertical colour bars
    function automatic logic [31:0] bar_pix(input logic [2:0] idx);
        unique case (idx)
            3'h0: bar_pix = 32'hFFEB_8080;
            3'h1: bar_pix = 32'hFFA2_2C8E;
            3'h2: bar_pix = 32'hFF83_9C2C;
            3'h3: bar_pix = 32'hFF70_483A;
            3'h4: bar_pix = 32'hFF54_B8C6;
            3'h5: bar_pix = 32'hFF41_64D4;
            3'h6: bar_pix = 32'hFF23_D472;
            3'h7: bar_pix = 32'hFF10_8080;
        endcase
    endfunction

    assign ext_sof = (st_r.a_sync == SYNC_REF) ? REF_SOF : IN_SOF;
    assign t_act = (32'(t_h) < H_ACT) && (32'(t_v) < V_ACT);

    vok_timing #(
        .H_TOT(H_TOT),
        .V_TOT(V_TOT)
    ) u_timing (
        .clk(CLK),
        .rst_n(RESETN),
        .adv(adv),
        .lock(st_r.a_sync != SYNC_FREE),
        .ext_sof(ext_sof),
        .hofs(st_r.a_hofs),
        .vofs(st_r.a_vofs),
        .h(t_h),
        .v(t_v),
        .last(t_last)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        mem_we = 1'b0;
        mem_wa = fb_addr(t_h, t_v);
        mem_wd = APP_PIX;
        dx = '0;
        dy = '0;

        // Register writes
        if (REG_WR)
        begin
            case (REG_ADDR)
                OFS_CTRL: st_nxt.ctrl = REG_WDATA[9:0];
                OFS_HOFS: st_nxt.hofs = REG_WDATA[H_W-1:0];
                OFS_VOFS: st_nxt.vofs = REG_WDATA[V_W-1:0];
                OFS_MATTE: st_nxt.matte = REG_WDATA[23:0];
                OFS_IMG_SIZE:
                begin
                    st_nxt.img_w = REG_WDATA[H_W-1:0];
                    st_nxt.img_h = REG_WDATA[IMG_H_LSB +: V_W];
                    st_nxt.ld_col = '0;
                    st_nxt.ld_row = '0;
                end
                OFS_PATTERN:
                begin
                    if (st_r.fill == FILL_IDLE)
                    begin
                        st_nxt.fill = FILL_RUN;
                        st_nxt.fx = '0;
                        st_nxt.fy = '0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Register reads, answered next cycle
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_CTRL: st_nxt.rdata = {22'h00_0000, st_r.ctrl};
                OFS_HOFS: st_nxt.rdata = 32'(st_r.hofs);
                OFS_VOFS: st_nxt.rdata = 32'(st_r.vofs);
                OFS_MATTE: st_nxt.rdata = {8'h00, st_r.matte};
                OFS_IMG_SIZE: st_nxt.rdata = (32'(st_r.img_h) << IMG_H_LSB) | 32'(st_r.img_w);
                OFS_STATUS: st_nxt.rdata = {25'h000_0000, APP_ACTIVE,
                                            st_r.fill == FILL_RUN, st_r.a_prem,
                                            st_r.a_key, st_r.a_sync};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Single write port: pattern fill, then image load, then capture
        if (st_r.fill == FILL_RUN)
        begin
            mem_we = 1'b1;
            mem_wa = fb_addr(st_r.fx, st_r.fy);
            mem_wd = bar_pix(3'(32'(st_r.fx) * 8 / H_ACT));
            if (32'(st_r.fx) == H_ACT - 1)
            begin
                st_nxt.fx = '0;
                st_nxt.fy = st_r.fy + 1'b1;
                if (32'(st_r.fy) == V_ACT - 1)
                    st_nxt.fill = FILL_IDLE;
            end
            else
                st_nxt.fx = st_r.fx + 1'b1;
        end
        else if (REG_WR && REG_ADDR == OFS_IMG_DATA)
        begin
            // No scaling: centre a small image, clip a large one
            dx = st_r.ld_col;
            dy = st_r.ld_row;
            if (32'(st_r.img_w) < H_ACT)
                dx = st_r.ld_col + H_W'((H_ACT - 32'(st_r.img_w)) / 2);
            if (32'(st_r.img_h) < V_ACT)
                dy = st_r.ld_row + V_W'((V_ACT - 32'(st_r.img_h)) / 2);
            if (32'(dx) < H_ACT && 32'(dy) < V_ACT && st_r.ld_row < st_r.img_h)
            begin
                mem_we = 1'b1;
                mem_wa = fb_addr(dx, dy);
                mem_wd = REG_WDATA;
            end
            if (st_r.ld_col + 1'b1 >= st_r.img_w)
            begin
                st_nxt.ld_col = '0;
                st_nxt.ld_row = st_r.ld_row + 1'b1;
            end
            else
                st_nxt.ld_col = st_r.ld_col + 1'b1;
        end
        else if (adv && APP_ACTIVE && t_act)
        begin
            // Capture for the hold default
            mem_we = 1'b1;
        end

        // Sample sources at the raster position
        if (adv)
        begin
            st_nxt.s1.vld = 1'b1;
            st_nxt.s1.sof = (t_h == '0) && (t_v == '0);
            st_nxt.s1.act = t_act;
            st_nxt.s1.app = APP_ACTIVE;
            st_nxt.s1.src = vok_src_type'(st_r.ctrl[CTRL_SRC_LSB +: 3]);
            st_nxt.s1.key = st_r.a_key;
            st_nxt.s1.prem = st_r.a_prem;
            st_nxt.s1.in_pix = IN_PIX;
            st_nxt.s1.desk_pix = DESK_PIX;
            st_nxt.s1.app_pix = APP_PIX;
            if (t_last)
            begin
                // Frame settings switch between frames
                st_nxt.a_sync = vok_sync_type'(st_r.ctrl[CTRL_SYNC_LSB +: 2]);
                st_nxt.a_hofs = st_r.hofs;
                st_nxt.a_vofs = st_r.vofs;
                st_nxt.a_prem = st_r.ctrl[CTRL_PREM_BIT];
                if (st_r.ctrl[CTRL_HD_BIT])
                    st_nxt.a_key = KEY_OFF;
                else
                    st_nxt.a_key = vok_key_type'(st_r.ctrl[CTRL_KEY_LSB +: 2]);
            end
        end

        st_nxt.aud = st_r.ctrl[CTRL_AUD_BIT] ? IN_AUD : FB_AUD;
    end

    // Program source selection
    always_comb
    begin
        if (st_r.s1.app)
            pgm = st_r.s1.app_pix;
        else
        begin
            unique case (st_r.s1.src)
                SRC_DESK: pgm = st_r.s1.desk_pix;
                SRC_PASS: pgm = st_r.s1.in_pix;
                SRC_BLACK: pgm = BLACK_PIX;
                SRC_TEST: pgm = mem_q;
                SRC_HOLD: pgm = mem_q;
                default: pgm = BLACK_PIX;
            endcase
        end
        unique case (st_r.s1.key)
            KEY_MATTE: outp = comp(pgm, {8'hFF, st_r.matte}, st_r.s1.prem);
            KEY_INPUT: outp = comp(pgm, st_r.s1.in_pix, st_r.s1.prem);
            default: outp = pgm;
        endcase
        if (!st_r.s1.act)
            outp = BLACK_PIX;
        vid_in.sof = st_r.s1.sof;
        vid_in.pix = outp[23:0];
    end

    vok_skid #(
        .W($bits(vok_vid_type))
    ) u_skid (
        .clk(CLK),
        .rst_n(RESETN),
        .in_valid(st_r.s1.vld),
        .in_ready(adv),
        .in_data(vid_in),
        .out_valid(VID_VALID),
        .out_ready(VID_READY),
        .out_data(vid_out)
    );

    // Store has no reset: contents only change by fill, load or capture
    always_ff @(posedge CLK)
    begin
        if (mem_we)
            fstore[mem_wa] <= mem_wd;
        if (adv)
            mem_q <= fstore[fb_addr(t_h, t_v)];
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.matte <= MATTE_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign REG_RDATA = st_r.rdata;
    assign RASTER_X = t_h;
    assign RASTER_Y = t_v;
    assign VID_SOF = vid_out.sof;
    assign VID_PIX = vid_out.pix;
    assign AUD_OUT = st_r.aud;
endmodule

// File: test/vok_assertions.sv
// Port checks for the program output stage, bound into vok_top.
// Assumes one clock; control tracked from register writes.
`timescale 1ns/1ps
module vok_check
    import vok_pkg::*;
#(
    parameter int H_TOT = H_TOT_DEF,
    parameter int V_TOT = V_TOT_DEF
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // Sources and sync
    input wire logic APP_ACTIVE,
    input wire logic REF_SOF,
    input wire logic IN_SOF,
    input wire logic [H_W-1:0] RASTER_X,
    input wire logic [V_W-1:0] RASTER_Y,
    // Video and audio
    input wire logic VID_VALID,
    input wire logic VID_READY,
    input wire logic VID_SOF,
    input wire logic [23:0] VID_PIX,
    input wire logic [23:0] FB_AUD,
    input wire logic [23:0] IN_AUD,
    input wire logic [23:0] AUD_OUT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    // One frame of pops passes a boundary
    localparam int SETTLE = H_TOT * V_TOT + 4;
    logic [9:0] ctrl_r;
    logic app_r;
    int settle_r;
    logic settled;
    assign settled = settle_r > SETTLE;
    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
            ctrl_r <= CTRL_RST;
        else if (REG_WR && REG_ADDR == OFS_CTRL)
            ctrl_r <= REG_WDATA[9:0];
    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
            app_r <= 1'b0;
        else
            app_r <= APP_ACTIVE;
    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
            settle_r <= 0;
        else if ((REG_WR && REG_ADDR == OFS_CTRL) || app_r != APP_ACTIVE)
            settle_r <= 0;
        else if (VID_VALID && VID_READY && !settled)
            settle_r <= settle_r + 1;
    sequence s_stalled;
        VID_VALID && !VID_READY;
    endsequence
    sequence s_full;
        s_stalled [*6];
    endsequence
    a_rdata_idle_zero: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
        else $error("idle read data not zero");
    a_ctrl_read_back: assert property (REG_RD && REG_ADDR == OFS_CTRL
        |=> REG_RDATA == 32'(ctrl_r))
        else $error("control read back differs");
    a_unmapped_read: assert property (REG_RD && REG_ADDR > OFS_STATUS
        |=> REG_RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_active: assert property (REG_RD && REG_ADDR == OFS_STATUS && settled
        |=> REG_RDATA[4:0] == {ctrl_r[7], ctrl_r[9] ? 2'b00 : ctrl_r[6:5], ctrl_r[4:3]})
        else $error("active settings differ");
    a_audio_pick: assert property ($past(RESETN) && $stable(ctrl_r[8])
        |-> AUD_OUT == (ctrl_r[8] ? $past(IN_AUD) : $past(FB_AUD)))
        else $error("wrong audio source");
    a_black_default: assert property (settled && VID_VALID && !APP_ACTIVE
        && ctrl_r[2:0] == SRC_BLACK && ctrl_r[6:5] == KEY_OFF
        |-> VID_PIX == BLACK_PIX[23:0])
        else $error("black default not black");
    a_stall_hold: assert property (s_stalled
        |=> VID_VALID && $stable(VID_PIX) && $stable(VID_SOF))
        else $error("pixel changed during stall");
    a_raster_freeze: assert property (s_full ##0 (!REF_SOF && !IN_SOF)
        |=> $stable(RASTER_X) && $stable(RASTER_Y))
        else $error("raster moved while full");
endmodule
bind vok_top vok_check #(.H_TOT(H_TOT), .V_TOT(V_TOT)) u_check (.*);

// File: test/vok_host.sv
// Host stand-in: raster-keyed sources, a stalling receiver.
// Keeps the last frame accepted; assumes raster order.
`timescale 1ns/1ps
module vok_host
    import vok_pkg::*;
#(
    parameter int HT = 20,
    parameter int VT = 10
)
(
    // Clock
    input wire logic clk,
    // Raster and knobs
    input wire logic [H_W-1:0] rx,
    input wire logic [V_W-1:0] ry,
    input wire logic [7:0] alpha,
    input wire logic slow,
    input wire logic freeze,
    // Pixel sources
    output vok_pix_type app_pix,
    output vok_pix_type in_pix,
    output vok_pix_type desk_pix,
    // Video receiver
    input wire logic vvalid,
    input wire logic vsof,
    input wire logic [23:0] vpix,
    output logic vready = 1'b0,
    output int frames = 0
);
    logic [23:0] got [HT*VT];
    int pos = 0;
    logic [1:0] cnt = 2'b00;
    // Position in the low bytes makes a misplaced pixel visible
    assign app_pix = {alpha, 8'hC0, rx[7:0], ry[7:0]};
    assign in_pix = {8'hFF, 8'h80, rx[7:0], ry[7:0]};
    assign desk_pix = {8'hFF, 8'h40, rx[7:0], ry[7:0]};
    always @(posedge clk)
    begin
        cnt <= cnt + 2'd1;
        vready <= !(freeze || (slow && cnt == 2'd0));
        if (vvalid && vready && (vsof || pos < HT * VT))
        begin
            got[vsof ? 0 : pos] <= vpix;
            pos <= vsof ? 1 : pos + 1;
            frames <= frames + (vsof ? 1 : 0);
        end
    end
endmodule

// File: test/vok_top_tb.sv
// Self-checking bench for the program output stage.
// Assumes a shortened raster so that one frame is 200 pixels.
`timescale 1ns/1ps
module vok_top_tb;
    import vok_pkg::*;
    localparam int HA = 16;
    localparam int VA = 8;
    localparam int HT = 20;
    localparam int VT = 10;
    typedef struct packed {
        logic [9:0] ctrl;
        logic app;
        logic [7:0] alpha;
        logic [1:0] kind;
        logic [7:0] base;
    } vok_row_type;
    vok_row_type rows [11] = '{
        '{10'h002, 1'b0, 8'hFF, 2'd0, 8'h00}, '{10'h000, 1'b0, 8'hFF, 2'd1, 8'h40},
        '{10'h001, 1'b0, 8'hFF, 2'd1, 8'h80}, '{10'h000, 1'b1, 8'hFF, 2'd1, 8'hC0},
        '{10'h004, 1'b0, 8'hFF, 2'd1, 8'hC0}, '{10'h001, 1'b0, 8'hFF, 2'd1, 8'h80},
        '{10'h004, 1'b0, 8'hFF, 2'd1, 8'hC0}, '{10'h020, 1'b1, 8'h00, 2'd3, 8'h00},
        '{10'h040, 1'b1, 8'h00, 2'd1, 8'h80}, '{10'h0C0, 1'b1, 8'h00, 2'd2, 8'h00},
        '{10'h220, 1'b1, 8'h00, 2'd1, 8'hC0}};
    logic [7:0] ra [5] = '{OFS_CTRL, OFS_HOFS, OFS_VOFS, OFS_MATTE, 8'h20};
    logic [31:0] rv [5] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0000,
        32'h0010_8080, 32'h0000_0000};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0, rd = 1'b0, ref_sof = 1'b0, in_sof = 1'b0;
    logic app = 1'b0, slow = 1'b0, freeze = 1'b0;
    logic [7:0] addr = 8'h00, alpha = 8'hFF;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic [23:0] fb_aud = 24'hA1_B2C3, in_aud = 24'h0D_0E0F, vpix, aud;
    logic [H_W-1:0] rx;
    logic [V_W-1:0] ry;
    logic vvalid, vready, vsof;
    logic [21:0] pos;
    vok_pix_type app_pix, in_pix, desk_pix;
    int error_cnt = 0, checks_done = 0, frames;
    always #5 clk = ~clk;
    vok_top #(.H_ACT(HA), .V_ACT(VA), .H_TOT(HT), .V_TOT(VT)) dut (
        .CLK(clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .APP_ACTIVE(app), .APP_PIX(app_pix),
        .IN_PIX(in_pix), .DESK_PIX(desk_pix), .REF_SOF(ref_sof), .IN_SOF(in_sof),
        .RASTER_X(rx), .RASTER_Y(ry), .VID_VALID(vvalid), .VID_READY(vready),
        .VID_SOF(vsof), .VID_PIX(vpix), .FB_AUD(fb_aud), .IN_AUD(in_aud), .AUD_OUT(aud));
    vok_host #(.HT(HT), .VT(VT)) host (.clk(clk), .rx(rx), .ry(ry), .alpha(alpha),
        .slow(slow), .freeze(freeze), .app_pix(app_pix), .in_pix(in_pix),
        .desk_pix(desk_pix), .vvalid(vvalid), .vsof(vsof), .vpix(vpix), .vready(vready),
        .frames(frames));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_frames(input int n);
        int t;
        t = frames + n;
        for (int i = 0; i < 1000 * n && frames < t; i++)
            @(posedge clk);
        if (frames < t)
            error_cnt++;
    endtask
    task automatic pulse(input logic on_input);
        @(posedge clk);
        in_sof <= on_input;
        ref_sof <= !on_input;
        @(posedge clk);
        in_sof <= 1'b0;
        ref_sof <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    function automatic logic [23:0] exp_pix(vok_row_type r, int x, int y);
        if (x >= HA || y >= VA || r.kind == 2'd0)
            return BLACK_PIX[23:0];
        if (r.kind == 2'd3)
            return 24'h50_6070;
        if (r.kind == 2'd2)
            return {8'hFF, 8'(2 * x), 8'(2 * y)};
        return {r.base, 8'(x), 8'(y)};
    endfunction
    task automatic results;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wr_reg(OFS_MATTE, 32'h0050_6070);
        foreach (rows[i])
        begin
            app <= rows[i].app;
            alpha <= rows[i].alpha;
            slow <= i[0];
            wr_reg(OFS_CTRL, 32'(rows[i].ctrl));
            wait_frames(3);
            for (int k = 0; k < HT * VT; k++)
                chk(32'(host.got[k]), 32'(exp_pix(rows[i], k % HT, k / HT)));
            rd_reg(OFS_STATUS, d);
        end
        app <= 1'b0;
        wr_reg(OFS_IMG_SIZE, 32'h0002_0004);
        for (int j = 0; j < 12; j++)
            wr_reg(OFS_IMG_DATA, 32'(j));
        wr_reg(OFS_CTRL, 32'h0000_0003);
        wait_frames(3);
        chk(32'(host.got[3 * HT + 7]), 32'h0000_0001);
        chk(32'(host.got[4 * HT + 9]), 32'h0000_0007);
        chk(32'(host.got[5 * HT + 6]), 32'h00C0_0605);
        wr_reg(OFS_HOFS, 32'h0000_0003);
        wr_reg(OFS_VOFS, 32'h0000_0002);
        rd_reg(OFS_HOFS, d);
        chk(d, 32'h0000_0003);
        // Stalled receiver freezes the raster, so only a sync load moves it
        for (int m = 0; m < 3; m++)
        begin
            freeze <= 1'b0;
            wr_reg(OFS_CTRL, 32'h0000_0002 | 32'(m << 3));
            wait_frames(2);
            freeze <= 1'b1;
            repeat (8) @(posedge clk);
            #1 pos = {rx, ry};
            pulse(m == 1);
            chk({10'h000, rx, ry}, {10'h000, pos});
            if (m != 0)
            begin
                pulse(m == 2);
                chk({10'h000, rx, ry}, {10'h000, 12'(HT - 3), 10'(VT - 2)});
            end
        end
        freeze <= 1'b0;
        wr_reg(OFS_CTRL, 32'h0000_0102);
        repeat (3) @(posedge clk);
        #1 chk(32'(aud), 32'(in_aud));
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        foreach (ra[i])
        begin
            rd_reg(ra[i], d);
            chk(d, rv[i]);
        end
        chk(32'(aud), 32'(fb_aud));
        wr_reg(8'h24, 32'hFFFF_FFFF);
        rd_reg(OFS_CTRL, d);
        chk(d, 32'h0000_0002);
        results;
    end
    initial
    begin
        #400000;
        error_cnt++;
        results;
    end
endmodule
